// ===== design/hbu_cmp_if.sv
// Carrier between the register block and the comparator: configuration and
// bus sample toward the comparator, raw hit terms back.
// Assumes both ends run on the same clock; all signals are combinational.
interface hbu_cmp_if;
    logic [1:0] mode;
    logic first_ale;
    logic second_ale;
    logic byte_size;
    logic [7:0] ctl1;
    logic [15:0] bp_addr;
    logic [15:0] bp_data;
    logic [15:0] bus_addr;
    logic [15:0] bus_data;
    logic bus_read;
    logic first_hit;
    logic second_hit;

    modport ctl (
        output mode, first_ale, second_ale, byte_size, ctl1,
        output bp_addr, bp_data, bus_addr, bus_data, bus_read,
        input first_hit, second_hit
    );
    modport cmp (
        input mode, first_ale, second_ale, byte_size, ctl1,
        input bp_addr, bp_data, bus_addr, bus_data, bus_read,
        output first_hit, second_hit
    );
endinterface : hbu_cmp_if

// ===== design/hbu_match.sv
// Address and data comparator of the breakpoint unit; purely combinational.
// Assumes the caller qualifies hits by bus cycle, fetch and debug state.
module hbu_match
    import hbu_pkg::*;
(
    hbu_cmp_if.cmp c
);

    ////////////////////////////////////////////////////////////////////////////
    // Byte compare that can be masked out.
    function automatic logic byte_ok(input logic use_it, input logic [7:0] a,
                                     input logic [7:0] b);
        byte_ok = !use_it || (a == b);
    endfunction : byte_ok

    // Direction qualifier: value 0 matches writes, 1 matches reads.
    function automatic logic dir_ok(input logic en, input logic val,
                                    input logic rd);
        dir_ok = !en || (val == rd);
    endfunction : dir_ok

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode.
    wire sw_dual = (c.mode == MODE_INT_DUAL);
    wire full_mode = (c.mode == MODE_DBG_FULL);
    wire dual_mode = sw_dual || (c.mode == MODE_DBG_DUAL);

    // Direction checks are dropped in the software-interrupt mode.
    wire first_dir = sw_dual || dir_ok(c.ctl1[CTL1_FIRST_DIRE],
        c.ctl1[CTL1_FIRST_DIRV], c.bus_read);
    wire second_dir = sw_dual || dir_ok(c.ctl1[CTL1_SECOND_DIRE],
        c.ctl1[CTL1_SECOND_DIRV], c.bus_read);

    // First breakpoint: high byte always, low byte only when enabled.
    wire first_addr = byte_ok(1'b1, c.bus_addr[15:8], c.bp_addr[15:8]) &&
        byte_ok(c.first_ale, c.bus_addr[7:0], c.bp_addr[7:0]);

    // Second address breakpoint uses the data pair against the address bus.
    wire second_addr = byte_ok(1'b1, c.bus_addr[15:8], c.bp_data[15:8]) &&
        byte_ok(c.second_ale, c.bus_addr[7:0], c.bp_data[7:0]);

    // Data compare in full mode, with byte masks; byte size keeps low byte.
    wire dcmp = c.ctl1[CTL1_SECOND_CMP];
    wire hi_use = !c.ctl1[CTL1_DATA_HMASK] && !c.byte_size;
    wire lo_use = !c.ctl1[CTL1_DATA_LMASK];
    wire data_ok = !dcmp || (byte_ok(hi_use, c.bus_data[15:8], c.bp_data[15:8]) &&
        byte_ok(lo_use, c.bus_data[7:0], c.bp_data[7:0]));

    // Hit terms: full mode folds data into the first hit.
    assign c.first_hit = first_addr && first_dir && (!full_mode || data_ok);
    assign c.second_hit = dual_mode && dcmp && second_addr && second_dir;

endmodule : hbu_match

// ===== design/hbu_pkg.sv
// Shared constants for the hardware breakpoint unit: register map, field
// positions, reset values, mode encodings and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit CPU address/data bus.
package hbu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CTL0 = 8'h20;
    localparam logic [7:0] IDX_CTL1 = 8'h21;
    localparam logic [7:0] IDX_ADDR_HI = 8'h22;
    localparam logic [7:0] IDX_ADDR_LO = 8'h23;
    localparam logic [7:0] IDX_DATA_HI = 8'h24;
    localparam logic [7:0] IDX_DATA_LO = 8'h25;
    localparam logic [7:0] IDX_STATUS = 8'h26;

    ////////////////////////////////////////////////////////////////////////////
    // Control register zero fields.
    localparam int CTL0_MODE_HI = 7;
    localparam int CTL0_MODE_LO = 6;
    localparam int CTL0_PROG_ONLY = 5;
    localparam int CTL0_BYTE_SIZE = 2;
    localparam int CTL0_SECOND_ALE = 1;
    localparam int CTL0_FIRST_ALE = 0;
    localparam logic [7:0] CTL0_WMASK = 8'he7;

    // Control register one fields; bit 7 always reads zero.
    localparam int CTL1_SECOND_CMP = 6;
    localparam int CTL1_DATA_HMASK = 5;
    localparam int CTL1_DATA_LMASK = 4;
    localparam int CTL1_SECOND_DIRE = 3;
    localparam int CTL1_SECOND_DIRV = 2;
    localparam int CTL1_FIRST_DIRE = 1;
    localparam int CTL1_FIRST_DIRV = 0;
    localparam logic [7:0] CTL1_WMASK = 8'h7f;

    // Status register fields.
    localparam int STAT_FIRST_HIT = 0;
    localparam int STAT_SECOND_HIT = 1;
    localparam int STAT_DEBUG_ACT = 2;

    // Reset values.
    localparam logic [7:0] CTL0_RESET = 8'h00;
    localparam logic [7:0] CTL1_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Breakpoint mode encodings.
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_INT_DUAL = 2'h1;
    localparam logic [1:0] MODE_DBG_FULL = 2'h2;
    localparam logic [1:0] MODE_DBG_DUAL = 2'h3;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : hbu_pkg

// ===== design/hbu_top.sv
// Hardware breakpoint unit: AXI4-Lite register slave plus breakpoint decision.
// Assumes CPU bus inputs synchronous to aclk, one sample per cycle while
// cpu_valid is high, and a core that acts on the one-cycle request pulses.
//
// Register access over AXI4-Lite is this design's own decision.

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Mode field 00 off, 01 dual software interrupt, 10 full debug, 11 dual debug.
// - No breakpoint matches while background debug mode is active.
// - Only dual software-interrupt mode raises interrupts, always as tagged fetch breaks.
// - Dual software-interrupt mode ignores all direction enable and value bits.
// - In dual modes the data-compare enable enables the second address breakpoint.
// - Byte size select does nothing in either dual mode.
// - Debug entry is requested only while the debug logic permits it.
// - Dual debug breakpoints use program-only, own range and own direction bits.
// - Full mode compares address pair to address bus, data pair to data.
// - Program-only clear breaks at boundary; set tags executed opcode fetches only.
// - Program-only bit is ignored in dual software-interrupt mode.
// - First low-address enable picks 8-bit or full 16-bit address compare.
// - Second low-address enable picks 8-bit or 16-bit compare in dual modes.
// - Data-compare enable clear keeps the data pair out of every compare.
// - High mask bit drops data bits 15:8 from full-mode compare.
// - Debug entry is not blocked by the debug monitor enable bit.
// - Control register one reads and writes always, bit 7 zero, resets zero.
// - Low mask bit drops data bits 7:0 from full-mode compare.
// - Direction enable set: value 0 matches writes, 1 matches reads.
module hbu_top
    import hbu_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address channel.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU core bus sample.
    input wire logic cpu_valid,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_data,
    input wire logic cpu_read,
    input wire logic cpu_fetch,
    // Background debug logic.
    input wire logic debug_active,
    input wire logic debug_permit,
    // Break requests toward the core.
    output logic tag_req,
    output logic tag_int,
    output logic debug_break
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check: the map needs byte addresses up to 0x9b.
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_width
        $error("hbu_top: ADDR_W must lie between 8 and 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0] ctl0_r;
    logic [7:0] ctl1_r;
    logic [7:0] addr_hi_r;
    logic [7:0] addr_lo_r;
    logic [7:0] data_hi_r;
    logic [7:0] data_lo_r;
    logic [1:0] hit_r;
    logic [1:0] hit_nxt;

    // Write channel state.
    logic aw_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic w_strb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    // Read channel state.
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Break request flops.
    logic tag_req_r;
    logic tag_int_r;
    logic debug_break_r;

    ////////////////////////////////////////////////////////////////////////////
    // Word index of a byte address; the low two bits are dropped.
    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
        logic [31:0] wide;
        wide = 32'h0;
        wide[ADDR_W-1:0] = a;
        word_idx = (wide[31:10] == 22'h0) ? wide[9:2] : 8'hff;
    endfunction : word_idx

    // True when an index names a mapped register.
    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx >= IDX_CTL0) && (idx <= IDX_STATUS);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////
    // Write handshake decode: address and data may arrive in either order.
    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take = s_axi_wvalid && wready_r;
    wire aw_have = aw_held_r || aw_take;
    wire w_have = w_held_r || w_take;
    wire do_wr = aw_have && w_have;
    wire [ADDR_W-1:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire wr_strb = w_held_r ? w_strb_r : s_axi_wstrb[0];
    wire [7:0] wr_idx = word_idx(wr_addr);
    wire wr_en = do_wr && wr_strb;
    wire [7:0] wb = wr_data[7:0];
    wire b_done = bvalid_r && s_axi_bready;
    wire bvalid_nxt = do_wr || (bvalid_r && !s_axi_bready);
    wire aw_held_nxt = aw_have && !do_wr;
    wire w_held_nxt = w_have && !do_wr;

    // Individual register write strobes.
    wire wr_ctl0 = wr_en && (wr_idx == IDX_CTL0);
    wire wr_ctl1 = wr_en && (wr_idx == IDX_CTL1);
    wire wr_ahi = wr_en && (wr_idx == IDX_ADDR_HI);
    wire wr_alo = wr_en && (wr_idx == IDX_ADDR_LO);
    wire wr_dhi = wr_en && (wr_idx == IDX_DATA_HI);
    wire wr_dlo = wr_en && (wr_idx == IDX_DATA_LO);
    wire wr_stat = wr_en && (wr_idx == IDX_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // Read decode.
    wire ar_take = s_axi_arvalid && arready_r;
    wire r_done = rvalid_r && s_axi_rready;
    wire [7:0] rd_idx = word_idx(s_axi_araddr);
    wire [7:0] stat_val = {5'h0, debug_active, hit_r};
    wire [7:0] rd_byte =
        (rd_idx == IDX_CTL0) ? ctl0_r :
        (rd_idx == IDX_CTL1) ? ctl1_r :
        (rd_idx == IDX_ADDR_HI) ? addr_hi_r :
        (rd_idx == IDX_ADDR_LO) ? addr_lo_r :
        (rd_idx == IDX_DATA_HI) ? data_hi_r :
        (rd_idx == IDX_DATA_LO) ? data_lo_r :
        (rd_idx == IDX_STATUS) ? stat_val : 8'h00;
    wire [1:0] rd_resp = mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
    wire [1:0] wr_resp = mapped(wr_idx) ? RESP_OKAY : RESP_DECERR;

    ////////////////////////////////////////////////////////////////////////////
    // Comparator hookup.
    hbu_cmp_if cif ();

    assign cif.mode = ctl0_r[CTL0_MODE_HI:CTL0_MODE_LO];
    assign cif.first_ale = ctl0_r[CTL0_FIRST_ALE];
    assign cif.second_ale = ctl0_r[CTL0_SECOND_ALE];
    assign cif.byte_size = ctl0_r[CTL0_BYTE_SIZE];
    assign cif.ctl1 = ctl1_r;
    assign cif.bp_addr = {addr_hi_r, addr_lo_r};
    assign cif.bp_data = {data_hi_r, data_lo_r};
    assign cif.bus_addr = cpu_addr;
    assign cif.bus_data = cpu_data;
    assign cif.bus_read = cpu_read;

    hbu_match u_match (
        .c(cif.cmp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Break decision.
    wire [1:0] mode = ctl0_r[CTL0_MODE_HI:CTL0_MODE_LO];
    wire sw_dual = (mode == MODE_INT_DUAL);
    wire brk_on = (mode != MODE_OFF);
    // Software-interrupt mode always works on tagged program fetches.
    wire prog_eff = sw_dual || ctl0_r[CTL0_PROG_ONLY];
    wire fetch_ok = !prog_eff || cpu_fetch;
    wire any_hit = cif.first_hit || cif.second_hit;
    wire live = cpu_valid && brk_on && !debug_active && fetch_ok;
    wire fire = live && any_hit;
    // Debug entry waits on the permit only; the monitor enable is not checked.
    wire dbg_ok = !sw_dual && debug_permit;
    wire tag_nxt = fire && prog_eff && (sw_dual || dbg_ok);
    wire int_nxt = fire && sw_dual;
    wire dbrk_nxt = fire && !prog_eff && dbg_ok;

    // Sticky hit flags; a new hit wins over a clear in the same cycle.
    always_comb begin
        hit_nxt = hit_r;
        if (wr_stat) begin
            hit_nxt = hit_r & ~wb[1:0];
        end
        if (live && cif.first_hit) begin
            hit_nxt[STAT_FIRST_HIT] = 1'b1;
        end
        if (live && cif.second_hit) begin
            hit_nxt[STAT_SECOND_HIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl0_r <= CTL0_RESET;
            ctl1_r <= CTL1_RESET;
        end else begin
            if (wr_ctl0) begin
                ctl0_r <= wb & CTL0_WMASK;
            end
            if (wr_ctl1) begin
                ctl1_r <= wb & CTL1_WMASK;
            end
        end
    end

    // Compare registers and hit flags.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_hi_r <= CMP_RESET;
            addr_lo_r <= CMP_RESET;
            data_hi_r <= CMP_RESET;
            data_lo_r <= CMP_RESET;
            hit_r <= 2'h0;
        end else begin
            addr_hi_r <= wr_ahi ? wb : addr_hi_r;
            addr_lo_r <= wr_alo ? wb : addr_lo_r;
            data_hi_r <= wr_dhi ? wb : data_hi_r;
            data_lo_r <= wr_dlo ? wb : data_lo_r;
            hit_r <= hit_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write address and data holding.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h0;
            w_strb_r <= 1'b0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            aw_addr_r <= aw_take ? s_axi_awaddr : aw_addr_r;
            w_data_r <= w_take ? s_axi_wdata : w_data_r;
            w_strb_r <= w_take ? s_axi_wstrb[0] : w_strb_r;
        end
    end

    // Write ready and response; readies drop while a response is pending.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            awready_r <= !aw_held_nxt && !bvalid_nxt;
            wready_r <= !w_held_nxt && !bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (do_wr) begin
                bresp_r <= wr_resp;
            end else if (b_done) begin
                bresp_r <= RESP_OKAY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one read in flight, data a cycle after the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= {24'h0, rd_byte};
                rresp_r <= rd_resp;
            end else if (r_done) begin
                arready_r <= 1'b1;
                rvalid_r <= 1'b0;
            end else begin
                arready_r <= !rvalid_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Break request pulses, one cycle after the matching bus sample.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tag_req_r <= 1'b0;
            tag_int_r <= 1'b0;
            debug_break_r <= 1'b0;
        end else begin
            tag_req_r <= tag_nxt;
            tag_int_r <= int_nxt;
            debug_break_r <= dbrk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops.
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign tag_req = tag_req_r;
    assign tag_int = tag_int_r;
    assign debug_break = debug_break_r;

endmodule : hbu_top

// ===== dv/hbu_assertions.sv
// Checker for the breakpoint unit's request outputs and register read data.
// Assumes it is bound to hbu_top and sees only its ports, one clock domain.
module hbu_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cpu_valid,
    input wire logic cpu_fetch,
    input wire logic debug_active,
    input wire logic debug_permit,
    input wire logic tag_req,
    input wire logic tag_int,
    input wire logic debug_break,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks sample on the bus clock and rest while reset is low.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////
    // Each request pulse must trace back to a live bus sample one cycle earlier.
    quiet_in_debug_a: assert property ((tag_req || debug_break) |->
        $past(cpu_valid) && !$past(debug_active)) else $error("request without live sample");
    soft_irq_tag_a: assert property (tag_int |-> tag_req)
        else $error("interrupt flag without tag");
    soft_irq_alone_a: assert property (tag_int |-> !debug_break)
        else $error("interrupt with debug entry");
    debug_permit_a: assert property (debug_break |-> $past(debug_permit))
        else $error("debug entry while not permitted");
    tag_permit_a: assert property (tag_req && !tag_int |-> $past(debug_permit))
        else $error("debug tag while not permitted");
    tag_on_fetch_a: assert property (tag_req |-> $past(cpu_fetch))
        else $error("tag without opcode fetch");
    tag_or_break_a: assert property (tag_req |-> !debug_break)
        else $error("tag and boundary break together");
    reset_quiet_a: assert property ($rose(aresetn) |-> !tag_req && !tag_int && !debug_break)
        else $error("request right after reset");
    read_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above low byte");
endmodule : hbu_assertions

// ===== dv/hbu_cpu_model.sv
// Model of the CPU core bus and the background debug logic.
// Assumes the bench calls sample() for each bus cycle it wants shown.
module hbu_cpu_model (
    input wire logic aclk,
    output logic cpu_valid,
    output logic [15:0] cpu_addr,
    output logic [15:0] cpu_data,
    output logic cpu_read,
    output logic cpu_fetch,
    output logic debug_active,
    output logic debug_permit,
    input wire logic tag_req,
    input wire logic tag_int,
    input wire logic debug_break
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle and debug entry permitted from time zero.
    initial begin
        {cpu_valid, cpu_addr, cpu_data, cpu_read, cpu_fetch, debug_active} = '0;
        debug_permit = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sets the debug state lines just after an edge.
    task automatic set_debug(input logic act, input logic perm);
        @(posedge aclk);
        debug_active <= act;
        debug_permit <= perm;
    endtask : set_debug

    // Shows one sample for one cycle and returns the requests it caused.
    task automatic sample(input logic [15:0] a, input logic [15:0] d, input logic rd,
        input logic f, output logic [2:0] r);
        @(posedge aclk);
        cpu_valid <= 1'b1;
        cpu_addr <= a;
        cpu_data <= d;
        cpu_read <= rd;
        cpu_fetch <= f;
        @(posedge aclk);
        // Released address, data and direction lines flip so a stale value cannot match by luck.
        cpu_valid <= 1'b0;
        cpu_addr <= ~a;
        cpu_data <= ~d;
        cpu_read <= ~rd;
        cpu_fetch <= 1'b0;
        #1;
        r = {tag_req, tag_int, debug_break};
    endtask : sample
endmodule : hbu_cpu_model

// ===== dv/test_hardware_breakpoint_unit.sv
// Self-checking bench: registers over AXI4-Lite, break requests from CPU samples.
// Assumes the package, design, CPU model and checker come first.
module test_hardware_breakpoint_unit;
    import hbu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, cpu_valid, cpu_read, cpu_fetch, debug_active, debug_permit;
    logic [15:0] cpu_addr, cpu_data;
    logic tag_req, tag_int, debug_break;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;

    hbu_top #(.ADDR_W(12)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cpu_valid, .cpu_addr, .cpu_data, .cpu_read, .cpu_fetch, .debug_active,
        .debug_permit, .tag_req, .tag_int, .debug_break);
    hbu_cpu_model i_cpu (.aclk, .cpu_valid, .cpu_addr, .cpu_data, .cpu_read, .cpu_fetch,
        .debug_active, .debug_permit, .tag_req, .tag_int, .debug_break);

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard.
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            test_done();
        end
    end

    // Compares one value and reports a mismatch.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Writes one register and checks the response code.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    // Reads one register and checks data and response code.
    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, d});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd

    // Shows one CPU sample; expected is {tag, interrupt, debug entry}.
    task automatic hit(input logic [15:0] a, input logic [15:0] d, input logic rn,
        input logic f, input logic [2:0] e);
        logic [2:0] r;
        i_cpu.sample(a, d, rn, f, r);
        chk({29'h0, r}, {29'h0, e});
    endtask : hit

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_CTL0, 8'h00, RESP_OKAY);
        rd(IDX_CTL1, 8'h00, RESP_OKAY);
        wr(IDX_CTL1, 8'hff, RESP_OKAY);
        rd(IDX_CTL1, 8'h7f, RESP_OKAY);
        wr(8'h30, 8'h55, RESP_DECERR);
        rd(8'h30, 8'h00, RESP_DECERR);
        wr(IDX_CTL1, 8'h00, RESP_OKAY);
        wr(IDX_ADDR_HI, 8'h12, RESP_OKAY);
        wr(IDX_ADDR_LO, 8'h34, RESP_OKAY);
        wr(IDX_DATA_HI, 8'h56, RESP_OKAY);
        wr(IDX_DATA_LO, 8'h78, RESP_OKAY);
        hit(16'h1234, 16'h0, 1, 1, 3'b000);
        wr(IDX_CTL0, 8'h80, RESP_OKAY);
        rd(IDX_CTL0, 8'h80, RESP_OKAY);
        hit(16'h12ff, 16'h0, 1, 0, 3'b001);
        hit(16'h13ff, 16'h0, 1, 0, 3'b000);
        wr(IDX_CTL0, 8'h81, RESP_OKAY);
        hit(16'h12ff, 16'h0, 1, 0, 3'b000);
        hit(16'h1234, 16'h0, 1, 0, 3'b001);
        i_cpu.set_debug(1'b1, 1'b1);
        hit(16'h1234, 16'h0, 1, 0, 3'b000);
        i_cpu.set_debug(1'b0, 1'b0);
        hit(16'h1234, 16'h0, 1, 0, 3'b000);
        i_cpu.set_debug(1'b0, 1'b1);
        wr(IDX_CTL1, 8'h40, RESP_OKAY);
        hit(16'h1234, 16'h5678, 1, 0, 3'b001);
        hit(16'h1234, 16'h5600, 1, 0, 3'b000);
        wr(IDX_CTL1, 8'h50, RESP_OKAY);
        hit(16'h1234, 16'h5600, 1, 0, 3'b001);
        wr(IDX_CTL1, 8'h60, RESP_OKAY);
        hit(16'h1234, 16'h0078, 1, 0, 3'b001);
        hit(16'h1234, 16'h0000, 1, 0, 3'b000);
        wr(IDX_CTL1, 8'h02, RESP_OKAY);
        hit(16'h1234, 16'h0, 1, 0, 3'b000);
        hit(16'h1234, 16'h0, 0, 0, 3'b001);
        wr(IDX_CTL0, 8'ha1, RESP_OKAY);
        hit(16'h1234, 16'h0, 0, 0, 3'b000);
        hit(16'h1234, 16'h0, 0, 1, 3'b100);
        wr(IDX_CTL0, 8'h41, RESP_OKAY);
        wr(IDX_CTL1, 8'h43, RESP_OKAY);
        hit(16'h1234, 16'h0, 0, 1, 3'b110);
        hit(16'h1234, 16'h0, 1, 0, 3'b000);
        i_cpu.set_debug(1'b0, 1'b0);
        hit(16'h56aa, 16'h0, 1, 1, 3'b110);
        i_cpu.set_debug(1'b0, 1'b1);
        wr(IDX_CTL1, 8'h03, RESP_OKAY);
        hit(16'h56aa, 16'h0, 1, 1, 3'b000);
        wr(IDX_CTL0, 8'hc7, RESP_OKAY);
        wr(IDX_CTL1, 8'h4c, RESP_OKAY);
        hit(16'h5678, 16'h0, 1, 0, 3'b001);
        hit(16'h5678, 16'h0, 0, 0, 3'b000);
        hit(16'h56aa, 16'h0, 1, 0, 3'b000);
        wr(IDX_STATUS, 8'h01, RESP_OKAY);
        rd(IDX_STATUS, 8'h02, RESP_OKAY);
        test_done();
    end
endmodule : test_hardware_breakpoint_unit

bind hbu_top hbu_assertions i_chk (.aclk, .aresetn, .cpu_valid, .cpu_fetch, .debug_active,
    .debug_permit, .tag_req, .tag_int, .debug_break, .s_axi_rvalid, .s_axi_rdata);
